// >>> common/pim_flag_if.sv
// Purpose: carries event sets, clears and sticky flags between modules
// Assumes: all signals on core_clk
// Notes: bit k of flags uses system field k, bit 6+k switch field k
interface pim_flag_if;
    logic [pim_pkg::PIM_NSRC-1:0] set;
    logic [pim_pkg::PIM_NSRC-1:0] clr;
    logic [pim_pkg::PIM_NSRC-1:0] flags;
    modport bank (input set, input clr, output flags);
    modport ctl (output set, output clr, input flags);
endinterface

// >>> common/pim_pkg.sv
// Purpose: constants shared by the interrupt mask logic
// Assumes: AHB-Lite word registers, 10 MHz core_clk
// Notes: register index times four gives the byte address
//
// What this block does
// - system mask bit 5 gates programming-voltage-low event onto the interrupt
// - system mask bit 4 gates mains-detect change event onto the interrupt
// - system mask bit 3 gates push-button change event onto the interrupt
// - system mask bit 2 gates thermal early-warning event onto the interrupt
// - system mask bit 1 gates coin-cell acquisition done event onto interrupt
// - system mask bit 0 gates nonvolatile programming done event onto interrupt
// - switch mask bit 5 gates switch 3 fault event onto the interrupt
// - switch mask bit 4 gates switch 2 fault event onto the interrupt
// - switch mask bit 3 gates switch 1 fault event onto the interrupt
// - switch mask bit 2 gates switch 3 current-limit event onto the interrupt
// - switch mask bit 1 gates switch 2 current-limit event onto the interrupt
// - switch mask bit 0 gates switch 1 current-limit event onto the interrupt
// - mask bit zero: a pending event pulls the interrupt pin low
// - mask bit one: the event leaves the interrupt pin alone
// - masking never stops detection or flag recording, only decouples the pin
// - switch mask register at index 0x04, resets to zero
// - system mask register at index 0x03, resets to zero
// - button change event fires on rising and falling edges alike
package pim_pkg;
    localparam int PIM_NSRC = 12;
    localparam int PIM_MW = 6;
    // register indices
    localparam logic [5:0] PIM_FLAG1_IDX = 6'h01;
    localparam logic [5:0] PIM_FLAG2_IDX = 6'h02;
    localparam logic [5:0] PIM_MASK1_IDX = 6'h03;
    localparam logic [5:0] PIM_MASK2_IDX = 6'h04;
    localparam logic [7:0] PIM_FLAG1_ADDR = {PIM_FLAG1_IDX, 2'b00};
    localparam logic [7:0] PIM_FLAG2_ADDR = {PIM_FLAG2_IDX, 2'b00};
    localparam logic [7:0] PIM_MASK1_ADDR = {PIM_MASK1_IDX, 2'b00};
    localparam logic [7:0] PIM_MASK2_ADDR = {PIM_MASK2_IDX, 2'b00};
    localparam logic [5:0] PIM_MASK_RST = 6'h00;
    localparam logic [5:0] PIM_FLAG_RST = 6'h00;
    // system register field positions
    localparam int PIM_PROG_V_BIT = 5;
    localparam int PIM_MAINS_BIT = 4;
    localparam int PIM_BUTTON_BIT = 3;
    localparam int PIM_THERMAL_BIT = 2;
    localparam int PIM_COIN_BIT = 1;
    localparam int PIM_NVM_BIT = 0;
    // switch register field positions
    localparam int PIM_SW3_FAULT_BIT = 5;
    localparam int PIM_SW2_FAULT_BIT = 4;
    localparam int PIM_SW1_FAULT_BIT = 3;
    localparam int PIM_SW3_CLIM_BIT = 2;
    localparam int PIM_SW2_CLIM_BIT = 1;
    localparam int PIM_SW1_CLIM_BIT = 0;
    // bus encodings
    localparam logic [1:0] PIM_HTRANS_NONSEQ = 2'h2;
    localparam logic PIM_HRESP_OKAY = 1'b0;
endpackage

// >>> logic/pim_flag_bank.sv
// Purpose: sticky pending flags for every interrupt source
// Assumes: set and clr are one-cycle pulses on core_clk
// Notes: a set in the clearing cycle wins so no event is lost
module pim_flag_bank (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // events and flags
    pim_flag_if.bank fb
);
    import pim_pkg::*;

    typedef struct packed {
        logic [PIM_NSRC-1:0] flags;
    } pim_bank_s;

    pim_bank_s q;
    pim_bank_s d;

    always_comb begin
        d = q;
        // masks are not seen here: recording never depends on them
        d.flags = (q.flags & ~fb.clr) | fb.set;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign fb.flags = q.flags;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_flag_records_any: assert property (|fb.set |=> ((fb.flags & $past(fb.set)) == $past(fb.set))) else $error("event not recorded");
    a_flag_holds_set: assert property ((fb.flags != 0) && (fb.clr == 0) |=> ((fb.flags & $past(fb.flags)) == $past(fb.flags))) else $error("flag lost without clear");
endmodule // pim_flag_bank

// >>> logic/pim_irq_mask.sv
// Purpose: interrupt masking stage with AHB-Lite register slave
// Assumes: source events are core_clk pulses, two pins are asynchronous
// Notes: zero wait states, every response OKAY
module pim_irq_mask (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // asynchronous pins
    input wire logic mains_detect_input,
    input wire logic button_input,
    // same-clock event pulses
    input wire logic prog_voltage_low_evt,
    input wire logic thermal_warning_evt,
    input wire logic coin_cell_acq_done_evt,
    input wire logic nvm_prog_done_evt,
    input wire logic [2:0] switch_fault_evt,
    input wire logic [2:0] switch_climit_evt,
    // interrupt pin to host
    output logic irq_out_n
);
    import pim_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [PIM_MW-1:0] sys_mask;
        logic [PIM_MW-1:0] sw_mask;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic irq_n;
    } pim_top_s;

    pim_top_s q;
    pim_top_s d;
    pim_flag_if fb ();
    logic [1:0] pin_change;
    logic addr_take;
    logic addr_ok;
    logic [PIM_NSRC-1:0] mask_all;
    logic [PIM_NSRC-1:0] flag_view;
    logic [PIM_NSRC-1:0] sys_set;

    pim_pin_sync #(.W(2)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin({mains_detect_input, button_input}),
        .level(),
        .change(pin_change)
    );

    pim_flag_bank u_bank (
        .core_clk(core_clk),
        .rst(rst),
        .fb(fb)
    );

    // event routing into the flag bank
    always_comb begin
        sys_set = '0;
        sys_set[PIM_PROG_V_BIT] = prog_voltage_low_evt;
        sys_set[PIM_MAINS_BIT] = pin_change[1];
        sys_set[PIM_BUTTON_BIT] = pin_change[0];
        sys_set[PIM_THERMAL_BIT] = thermal_warning_evt;
        sys_set[PIM_COIN_BIT] = coin_cell_acq_done_evt;
        sys_set[PIM_NVM_BIT] = nvm_prog_done_evt;
        sys_set[PIM_MW+PIM_SW3_FAULT_BIT] = switch_fault_evt[2];
        sys_set[PIM_MW+PIM_SW2_FAULT_BIT] = switch_fault_evt[1];
        sys_set[PIM_MW+PIM_SW1_FAULT_BIT] = switch_fault_evt[0];
        sys_set[PIM_MW+PIM_SW3_CLIM_BIT] = switch_climit_evt[2];
        sys_set[PIM_MW+PIM_SW2_CLIM_BIT] = switch_climit_evt[1];
        sys_set[PIM_MW+PIM_SW1_CLIM_BIT] = switch_climit_evt[0];
    end

    // write one to clear a flag, taken in the data phase
    always_comb begin
        fb.set = sys_set;
        fb.clr = '0;
        if (q.wr_pend && q.wr_addr == PIM_FLAG1_ADDR) begin
            fb.clr[PIM_MW-1:0] = hwdata[PIM_MW-1:0];
        end else if (q.wr_pend && q.wr_addr == PIM_FLAG2_ADDR) begin
            fb.clr[PIM_NSRC-1:PIM_MW] = hwdata[PIM_MW-1:0];
        end
    end

    // same as the bank's next value, so reads never see a stale flag
    assign flag_view = (fb.flags & ~fb.clr) | fb.set;
    assign mask_all = {q.sw_mask, q.sys_mask};
    assign addr_take = hsel && hready && htrans == PIM_HTRANS_NONSEQ;
    assign addr_ok = haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0;

    always_comb begin
        d = q;
        d.ready = 1'b1;
        d.resp = PIM_HRESP_OKAY;
        d.wr_pend = 1'b0;
        // data phase of a write; bits 31:6 have no storage
        if (q.wr_pend && q.wr_addr == PIM_MASK1_ADDR) begin
            d.sys_mask = hwdata[PIM_MW-1:0];
        end else if (q.wr_pend && q.wr_addr == PIM_MASK2_ADDR) begin
            d.sw_mask = hwdata[PIM_MW-1:0];
        end
        // address phase: latch writes, prepare read data
        if (addr_take) begin
            d.wr_pend = hwrite && addr_ok;
            d.wr_addr = haddr[7:0];
            d.rdata = 32'h00000000;
            if (!hwrite && addr_ok) begin
                if (haddr[7:0] == PIM_FLAG1_ADDR) begin
                    d.rdata[PIM_MW-1:0] = flag_view[PIM_MW-1:0];
                end else if (haddr[7:0] == PIM_FLAG2_ADDR) begin
                    d.rdata[PIM_MW-1:0] = flag_view[PIM_NSRC-1:PIM_MW];
                end else if (haddr[7:0] == PIM_MASK1_ADDR) begin
                    d.rdata[PIM_MW-1:0] = d.sys_mask;
                end else if (haddr[7:0] == PIM_MASK2_ADDR) begin
                    d.rdata[PIM_MW-1:0] = d.sw_mask;
                end
            end
        end
        // low while any flag has its mask bit clear, else released
        d.irq_n = ~|(fb.flags & ~mask_all);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q.wr_pend <= 1'b0;
            q.wr_addr <= 8'h00;
            q.sys_mask <= PIM_MASK_RST;
            q.sw_mask <= PIM_MASK_RST;
            q.rdata <= 32'h00000000;
            q.ready <= 1'b1;
            q.resp <= PIM_HRESP_OKAY;
            q.irq_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hreadyout = q.ready;
    assign hresp = q.resp;
    assign hrdata = q.rdata;
    assign irq_out_n = q.irq_n;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // per-source gating through the system mask
    for (genvar i = 0; i < PIM_MW; i++) begin : g_sys_chk
        a_sys_bit_gate: assert property (fb.flags[i] && !q.sys_mask[i] |=> !irq_out_n) else $error("unmasked system source left pin high");
    end

    // per-source gating through the switch mask
    for (genvar i = 0; i < PIM_MW; i++) begin : g_sw_chk
        a_sw_bit_gate: assert property (fb.flags[PIM_MW+i] && !q.sw_mask[i] |=> !irq_out_n) else $error("unmasked switch source left pin high");
    end

    sequence s_mask1_write;
        addr_take && hwrite && haddr[7:0] == PIM_MASK1_ADDR && haddr[31:8] == 24'h000000;
    endsequence

    sequence s_mask2_write;
        addr_take && hwrite && haddr[7:0] == PIM_MASK2_ADDR && haddr[31:8] == 24'h000000;
    endsequence

    a_unmasked_pulls_low: assert property ((fb.flags & ~mask_all) != 0 ##1 (fb.flags & ~mask_all) != 0 |=> !irq_out_n [*1]) else $error("pending unmasked event not signalled");
    a_masked_no_effect: assert property ((fb.flags & mask_all) != 0 && (fb.flags & ~mask_all) == 0 |=> irq_out_n) else $error("masked event pulled pin low");
    a_pin_released_high: assert property ((fb.flags & ~mask_all) == 0 |=> irq_out_n) else $error("pin held low with nothing pending");
    a_mask2_write_lands: assert property (s_mask2_write ##1 1'b1 |=> q.sw_mask == $past(hwdata[PIM_MW-1:0])) else $error("switch mask write not stored");
    a_mask1_write_lands: assert property (s_mask1_write ##1 1'b1 |=> q.sys_mask == $past(hwdata[PIM_MW-1:0])) else $error("system mask write not stored");
    a_mask_reset_zero: assert property ($past(rst) |-> q.sys_mask == 6'h00 && q.sw_mask == 6'h00) else $error("mask not zero after reset");
    a_reserved_read_zero: assert property (hrdata[31:PIM_MW] == 26'h0000000) else $error("reserved bits read nonzero");
    a_mask_keeps_flag: assert property (fb.set[PIM_MW-1:0] != 0 |=> (fb.flags[PIM_MW-1:0] & $past(fb.set[PIM_MW-1:0])) == $past(fb.set[PIM_MW-1:0])) else $error("masked event not recorded");
    a_button_edge_flags: assert property (pin_change[0] |=> fb.flags[PIM_BUTTON_BIT]) else $error("button change not flagged");
endmodule // pim_irq_mask

// >>> logic/pim_pin_sync.sv
// Purpose: two-flop pin synchroniser with any-edge change pulse
// Assumes: pins asynchronous to core_clk
// Notes: the first stage feeds only the second stage
module pim_pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pins
    input wire logic [W-1:0] pin,
    // synchronised view
    output logic [W-1:0] level,
    output logic [W-1:0] change
);
    import pim_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [2:0] fill;
    } pim_sync_s;

    pim_sync_s q;
    pim_sync_s d;

    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.fill = {q.fill[1:0], 1'b1};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.s2;
    // either direction counts as a change
    // reset clears the stages, so a pin idling high would look like an edge;
    // changes wait until all three stages hold real samples, at the cost of
    // missing a pin move in the first cycle after reset, before the first sample
    assign change = (q.s2 ^ q.s3) & {W{q.fill[2]}};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    for (genvar i = 0; i < W; i++) begin : g_chk
        a_pin_any_edge: assert property ($changed(pin[i]) ##1 !$changed(pin[i]) ##1 !$changed(pin[i]) |-> change[i]) else $error("pin edge gave no change pulse");
    end
endmodule // pim_pin_sync

// >>> testbench/pim_host_model.sv
// Purpose: host processor end of the active-low interrupt line
// Assumes: host samples on core_clk
// Notes: reports the line as an active-high request seen by software
module pim_host_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // interrupt line from the device
    input wire logic irq_out_n,
    // host view
    output logic irq_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // host registers the line, so a one-cycle glitch would show late, never twice
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_seen <= 1'b0;
        end else begin
            irq_seen <= ~irq_out_n;
        end
    end
endmodule // pim_host_model

// >>> testbench/pmic_interrupt_mask_logic_bench.sv
// Purpose: self-checking bench for the interrupt mask logic
// Assumes: zero-wait ahb-lite slave, host model on the interrupt line
// Notes: flags and masks modelled in the bench, compared at every result
module pmic_interrupt_mask_logic_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import pim_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic mains = 1'b0;
    logic btn = 1'b1;
    logic [11:0] ev = 12'h000;
    logic irq_out_n;
    logic irq_seen;
    logic [11:0] fm = 12'h000;
    logic [11:0] mm = 12'h000;
    logic [31:0] rs = 32'hC7DF;
    logic [31:0] q;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    pim_irq_mask pim_irq_mask_i (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mains_detect_input(mains),
        .button_input(btn), .prog_voltage_low_evt(ev[5]), .thermal_warning_evt(ev[2]),
        .coin_cell_acq_done_evt(ev[1]), .nvm_prog_done_evt(ev[0]),
        .switch_fault_evt(ev[11:9]), .switch_climit_evt(ev[8:6]), .irq_out_n(irq_out_n));
    pim_host_model pim_host_model_i (.core_clk(core_clk), .rst(rst), .irq_out_n(irq_out_n),
        .irq_seen(irq_seen));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            error_cnt++;
        end
    endtask

    // single word transfer; starts and ends just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= PIM_HTRANS_NONSEQ;
        hwrite <= w;
        do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        q = hrdata;
        chk({31'h0, hresp}, {31'h0, PIM_HRESP_OKAY});
        if (n >= 50) begin
            error_cnt++;
        end
    endtask

    task automatic setm(input logic [11:0] m);
        xfer(1'b1, PIM_MASK1_ADDR, {26'h0, m[5:0]});
        xfer(1'b1, PIM_MASK2_ADDR, {26'h0, m[11:6]});
        mm = m;
    endtask

    // pins toggle for the two pin sources, the rest are one-cycle pulses
    task automatic fire(input logic [11:0] v);
        ev <= v & 12'hFE7;
        if (v[3]) btn <= ~btn;
        if (v[4]) mains <= ~mains;
        @(posedge core_clk);
        ev <= 12'h000;
        repeat (8) @(posedge core_clk);
        fm = fm | v;
    endtask

    task automatic chk_state();
        chk({31'h0, irq_seen}, {31'h0, |(fm & ~mm)});
        xfer(1'b0, PIM_FLAG1_ADDR, 32'h0);
        chk(q, {26'h0, fm[5:0]});
        xfer(1'b0, PIM_FLAG2_ADDR, 32'h0);
        chk(q, {26'h0, fm[11:6]});
        xfer(1'b1, PIM_FLAG1_ADDR, 32'h3F);
        xfer(1'b1, PIM_FLAG2_ADDR, 32'h3F);
        fm = 12'h000;
        repeat (3) @(posedge core_clk);
        chk({31'h0, irq_seen}, 32'h0);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        xfer(1'b0, PIM_MASK1_ADDR, 32'h0);
        chk(q, {26'h0, PIM_MASK_RST});
        xfer(1'b0, PIM_MASK2_ADDR, 32'h0);
        chk(q, {26'h0, PIM_MASK_RST});
        chk({31'h0, irq_seen}, 32'h0);
        // each source alone, first unmasked with the rest masked, then masked alone
        for (int k = 0; k < 12; k++) begin
            for (int mb = 0; mb < 2; mb++) begin
                setm(mb ? (12'h001 << k) : ~(12'h001 << k));
                fire(12'h001 << k);
                chk_state();
            end
        end
        xfer(1'b1, PIM_MASK1_ADDR, 32'hFFFFFFFF);
        xfer(1'b0, PIM_MASK1_ADDR, 32'h0);
        chk(q, 32'h0000003F);
        xfer(1'b1, PIM_MASK2_ADDR, 32'hFFFFFFC0);
        xfer(1'b0, PIM_MASK2_ADDR, 32'h0);
        chk(q, 32'h0);
        xfer(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 16; i++) begin
            rs = nxt(rs);
            setm(rs[11:0]);
            xfer(1'b0, PIM_MASK2_ADDR, 32'h0);
            chk(q, {26'h0, mm[11:6]});
            fire(rs[27:16]);
            chk_state();
        end
        close_out();
    end
endmodule // pmic_interrupt_mask_logic_bench
